// ---- shared/cca_pkg.sv ----
// Purpose: Shared constants and types for the counter array capture/compare block
// Assumes: One system clock, Avalon-MM register slave with 32-bit data
// Notes: Register indices are byte address divided by four
package cca_pkg;

    localparam int NUM_MOD = 3;
    localparam int CNT_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MASK = 8'hd7;
    localparam logic [7:0] IDX_STATUS = 8'hd8;
    localparam logic [7:0] IDX_CTRL = 8'hd9;
    localparam logic [7:0] IDX_MODE0 = 8'hda;
    localparam logic [7:0] IDX_MODE1 = 8'hdb;
    localparam logic [7:0] IDX_MODE2 = 8'hdc;
    localparam logic [7:0] IDX_CNT_LO = 8'hf9;
    localparam logic [7:0] IDX_CNT_HI = 8'hfa;
    localparam logic [7:0] IDX_CMPL0 = 8'hfb;
    localparam logic [7:0] IDX_CMPH0 = 8'hfc;
    localparam logic [7:0] IDX_CMPL1 = 8'he9;
    localparam logic [7:0] IDX_CMPH1 = 8'hea;
    localparam logic [7:0] IDX_CMPL2 = 8'heb;
    localparam logic [7:0] IDX_CMPH2 = 8'hec;

    // Field positions
    localparam int MODE_WIDE_BIT = 7;
    localparam int MODE_CMP_BIT = 6;
    localparam int MODE_RISE_BIT = 5;
    localparam int MODE_FALL_BIT = 4;
    localparam int MODE_MATCH_BIT = 3;
    localparam int MODE_TOGGLE_BIT = 2;
    localparam int MODE_PULSE_BIT = 1;
    localparam int MODE_IRQ_BIT = 0;
    localparam int CTRL_WD_BIT = 6;
    localparam int STATUS_RUN_BIT = 6;
    localparam int WD_MODULE = 2;

    // Values after reset
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic CTRL_WD_RST = 1'b1;
    localparam logic STATUS_RUN_RST = 1'b0;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;

    // Bit 7 down to bit 0 of a module mode register
    typedef struct packed {
        logic wideSel;
        logic compareEn;
        logic riseCap;
        logic fallCap;
        logic matchEn;
        logic toggleEn;
        logic pulseEn;
        logic irqEn;
    } cca_mode_t;

    // Per-module software write strobes with their byte
    typedef struct packed {
        logic wrLow;
        logic wrHigh;
        logic [7:0] data;
    } cca_cmp_wr_t;

    // Per-module state reported back to the register file
    typedef struct packed {
        logic flagSet;
        logic [15:0] compare;
    } cca_chan_t;

endpackage

// ---- hw/cca_flags.sv ----
// Purpose: Sticky capture/compare flags and the combined interrupt output
// Assumes: Clears are write-one-to-clear strobes from the register file
// Notes: A set in the same cycle as a clear keeps the flag set
module cca_flags #(
    parameter int N = cca_pkg::NUM_MOD
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [N-1:0] setEvt,
    input wire logic [N-1:0] clrMask,
    input wire logic [N-1:0] maskBits,
    output logic [N-1:0] flags,
    output logic irq
);
    import cca_pkg::*;

    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;
    logic irq_r;

    // Set wins over clear; hardware never clears on its own
    assign flags_nxt = (flags_r & ~clrMask) | setEvt;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flags_r <= '0;
            irq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            irq_r <= |(flags_nxt & maskBits);
        end
    end

    assign flags = flags_r;
    assign irq = irq_r;

endmodule

// ---- hw/cca_channel.sv ----
// Purpose: One capture/compare module: capture, match, toggle, pulse-width output
// Assumes: Pin input is synchronous to clk_sys
// Notes: Capture has priority over a software write to the compare value
module cca_channel (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire cca_pkg::cca_mode_t mode,
    input wire logic [15:0] counter,
    input wire cca_pkg::cca_cmp_wr_t cmpWr,
    input wire logic pinIn,
    output cca_pkg::cca_chan_t status,
    output logic pinOut,
    output logic pinOeN
);
    import cca_pkg::*;

    logic [15:0] cmp_r;
    logic pinPrev_r;
    logic pinOut_r;
    logic pinOeN_r;
    logic flagSet_r;
    logic pwm8;
    logic freqMode;
    logic matchLow;
    logic match16;
    logic matchEvt;
    logic capture;
    logic pwmLevel;
    logic pinNxt;
    logic drive;

    assign pwm8 = mode.pulseEn & ~mode.wideSel;
    assign freqMode = mode.toggleEn & mode.pulseEn;
    assign matchLow = counter[7:0] == cmp_r[7:0];
    assign match16 = counter == cmp_r;
    // Comparator only runs with compare enable set
    assign matchEvt = mode.compareEn & (pwm8 ? matchLow : match16);
    assign capture = (pinIn & ~pinPrev_r & mode.riseCap)
        | (~pinIn & pinPrev_r & mode.fallCap);
    // Output is low until the compare point, then high
    assign pwmLevel = mode.wideSel ? (counter >= cmp_r)
        : (counter[7:0] >= cmp_r[7:0]);
    assign pinNxt = freqMode ? (pinOut_r ^ (mode.compareEn & matchLow))
        : mode.pulseEn ? pwmLevel
        : mode.toggleEn ? (pinOut_r ^ matchEvt)
        : pinOut_r;
    assign drive = mode.compareEn & (mode.toggleEn | mode.pulseEn);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmp_r <= CMP_RST;
            pinPrev_r <= 1'b0;
            pinOut_r <= 1'b0;
            pinOeN_r <= 1'b1;
            flagSet_r <= 1'b0;
        end else begin
            pinPrev_r <= pinIn;
            pinOut_r <= pinNxt;
            pinOeN_r <= ~drive;
            flagSet_r <= (matchEvt & mode.matchEn) | capture;
            if (capture) begin
                cmp_r <= counter;
            end else if (cmpWr.wrLow) begin
                cmp_r[7:0] <= cmpWr.data;
            end else if (cmpWr.wrHigh) begin
                cmp_r[15:8] <= cmpWr.data;
            end
        end
    end

    assign status = '{flagSet: flagSet_r, compare: cmp_r};
    assign pinOut = pinOut_r;
    assign pinOeN = pinOeN_r;

endmodule

// ---- hw/cca_counter_array.sv ----
// Purpose: Counter array with three capture/compare modules behind Avalon-MM
// Assumes: Byte addressing, one aligned 32-bit word per register, data in bits 7:0
// Notes: Each access takes two edges; waitrequest drops for one cycle per access
module cca_counter_array (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [cca_pkg::NUM_MOD-1:0] modIoIn,
    output logic [cca_pkg::NUM_MOD-1:0] modIoOut,
    output logic [cca_pkg::NUM_MOD-1:0] modIoOeN,
    output logic irq,
    output logic wdTimeout
);
    import cca_pkg::*;

    localparam logic [7:0] IDX_MODE [NUM_MOD] = '{IDX_MODE0, IDX_MODE1, IDX_MODE2};
    localparam logic [7:0] IDX_CMPL [NUM_MOD] = '{IDX_CMPL0, IDX_CMPL1, IDX_CMPL2};
    localparam logic [7:0] IDX_CMPH [NUM_MOD] = '{IDX_CMPH0, IDX_CMPH1, IDX_CMPH2};

    // Bus handshake
    logic waitReq_r;
    logic [31:0] readData_r;
    logic take;
    logic wrAcc;
    logic rdTake;
    logic [7:0] idx;
    logic [7:0] wrByte;
    logic laneOk;

    // Control state
    cca_mode_t mode_r [NUM_MOD];
    cca_mode_t effMode [NUM_MOD];
    logic wdEnable_r;
    logic run_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0] snapHigh_r;
    logic wdTimeout_r;

    // Decodes
    logic hitMask;
    logic hitStatus;
    logic hitCtrl;
    logic hitCntLo;
    logic hitCntHi;
    logic [NUM_MOD-1:0] hitMode;
    logic [NUM_MOD-1:0] hitCmpL;
    logic [NUM_MOD-1:0] hitCmpH;
    logic [NUM_MOD-1:0] modeLocked;
    logic cntWrLo;
    logic cntWrHi;

    // Module links
    cca_chan_t chanStat [NUM_MOD];
    cca_cmp_wr_t cmpWr [NUM_MOD];
    logic [NUM_MOD-1:0] flagSet;
    logic [NUM_MOD-1:0] flagClr;
    logic [NUM_MOD-1:0] irqMask;
    logic [NUM_MOD-1:0] flags;
    logic [NUM_MOD-1:0] pinOut;
    logic [NUM_MOD-1:0] pinOeN;
    logic irqFlags;

    // Read mux and watchdog compare
    logic [7:0] rdByte;
    logic [7:0] modeRd;
    logic [7:0] cmpRd;
    logic wdHit;

    // A request is taken while waitrequest is high, completed once it is low
    assign take = (avs_read | avs_write) & waitReq_r;
    assign wrAcc = avs_write & ~waitReq_r;
    assign rdTake = avs_read & waitReq_r;
    assign idx = avs_address[9:2];
    assign laneOk = avs_byteenable[0];
    assign wrByte = avs_writedata[7:0];

    assign hitMask = idx == IDX_MASK;
    assign hitStatus = idx == IDX_STATUS;
    assign hitCtrl = idx == IDX_CTRL;
    assign hitCntLo = idx == IDX_CNT_LO;
    assign hitCntHi = idx == IDX_CNT_HI;

    // Counter writes are refused while the watchdog is enabled, even with the counter stopped
    assign cntWrLo = wrAcc & laneOk & hitCntLo & ~wdEnable_r;
    assign cntWrHi = wrAcc & laneOk & hitCntHi & ~wdEnable_r;

    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : gMod
            assign hitMode[g] = idx == IDX_MODE[g];
            assign hitCmpL[g] = idx == IDX_CMPL[g];
            assign hitCmpH[g] = idx == IDX_CMPH[g];
            // Software relies on turning the watchdog off before touching module 2
            assign modeLocked[g] = (g == WD_MODULE) & wdEnable_r;
            // Module 2 runs none of its own functions while it is the watchdog
            assign effMode[g] = modeLocked[g] ? cca_mode_t'(MODE_RST) : mode_r[g];
            assign cmpWr[g] = '{wrLow: wrAcc & laneOk & hitCmpL[g],
                                wrHigh: wrAcc & laneOk & hitCmpH[g],
                                data: wrByte};
            assign flagSet[g] = chanStat[g].flagSet;
            assign flagClr[g] = wrAcc & laneOk & hitStatus & wrByte[g];
            assign irqMask[g] = effMode[g].irqEn;

            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    mode_r[g] <= cca_mode_t'(MODE_RST);
                end else if (wrAcc & laneOk & ~modeLocked[g]) begin
                    if (hitMode[g]) begin
                        mode_r[g] <= cca_mode_t'(wrByte);
                    end else if (hitCmpL[g]) begin
                        mode_r[g].compareEn <= 1'b0;
                    end else if (hitMask) begin
                        mode_r[g].irqEn <= wrByte[g];
                    end
                end
            end

            cca_channel uChan (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .mode(effMode[g]),
                .counter(cnt_r),
                .cmpWr(cmpWr[g]),
                .pinIn(modIoIn[g]),
                .status(chanStat[g]),
                .pinOut(pinOut[g]),
                .pinOeN(pinOeN[g])
            );
        end
    endgenerate

    cca_flags #(
        .N(NUM_MOD)
    ) uFlags (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .setEvt(flagSet),
        .clrMask(flagClr),
        .maskBits(irqMask),
        .flags(flags),
        .irq(irqFlags)
    );

    // Software writes override counting in the same cycle
    always_comb begin
        cnt_nxt = run_r ? cnt_r + 16'h0001 : cnt_r;
        if (cntWrLo) begin
            cnt_nxt[7:0] = wrByte;
        end
        if (cntWrHi) begin
            cnt_nxt[15:8] = wrByte;
        end
    end

    // Watchdog expires when the counter reaches module 2's compare value
    assign wdHit = wdEnable_r & run_r & (cnt_r == chanStat[WD_MODULE].compare);

    // Read selection
    always_comb begin
        modeRd = 8'h00;
        cmpRd = 8'h00;
        for (int i = 0; i < NUM_MOD; i++) begin
            if (hitMode[i]) begin
                modeRd = mode_r[i];
            end
            if (hitCmpL[i]) begin
                cmpRd = chanStat[i].compare[7:0];
            end
            if (hitCmpH[i]) begin
                cmpRd = chanStat[i].compare[15:8];
            end
        end
    end

    assign rdByte = hitCntLo ? cnt_r[7:0]
        : hitCntHi ? snapHigh_r
        : hitStatus ? {1'b0, run_r, 3'b000, flags}
        : hitCtrl ? {1'b0, wdEnable_r, 6'b000000}
        : hitMask ? {5'b00000, irqMask}
        : (modeRd | cmpRd);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            waitReq_r <= 1'b1;
            readData_r <= 32'h00000000;
        end else begin
            waitReq_r <= ~take;
            if (rdTake) begin
                readData_r <= {24'h000000, rdByte};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= CNT_RST;
            snapHigh_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
            // Snapshot taken with the low byte so a 16-bit read is coherent
            if (rdTake & hitCntLo) begin
                snapHigh_r <= cnt_r[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdEnable_r <= CTRL_WD_RST;
            run_r <= STATUS_RUN_RST;
            wdTimeout_r <= 1'b0;
        end else begin
            wdTimeout_r <= wdHit;
            if (wrAcc & laneOk & hitCtrl) begin
                wdEnable_r <= wrByte[CTRL_WD_BIT];
            end
            if (wrAcc & laneOk & hitStatus) begin
                run_r <= wrByte[STATUS_RUN_BIT];
            end
        end
    end

    // Outputs come straight from flops in this file or in the module instances
    assign avs_readdata = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign modIoOut = pinOut;
    assign modIoOeN = pinOeN;
    assign irq = irqFlags;
    assign wdTimeout = wdTimeout_r;

endmodule

// ---- dv/cca_counter_array_asserts.sv ----
// Purpose: Port-level checks of the counter array block
// Assumes: Mode and watchdog shadows follow completed register writes
// Notes: Module 2 shadow freezes while the watchdog is on, as the block does
module cca_counter_array_asserts (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [cca_pkg::NUM_MOD-1:0] modIoIn,
    input wire logic [cca_pkg::NUM_MOD-1:0] modIoOut,
    input wire logic [cca_pkg::NUM_MOD-1:0] modIoOeN,
    input wire logic irq,
    input wire logic wdTimeout
);
    timeunit 1ns;
    timeprecision 1ps;
    import cca_pkg::*;
    localparam logic [7:0] CMPL [3] = '{IDX_CMPL0, IDX_CMPL1, IDX_CMPL2};
    logic [7:0] mode_r [3];
    logic wd_r;
    logic [2:0] ienW, drvW;
    wire logic [7:0] idx = avs_address[9:2];
    wire logic done = avs_write && !avs_waitrequest && avs_byteenable[0];
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_r <= '{default: MODE_RST};
            wd_r <= CTRL_WD_RST;
        end else if (done) begin
            if (idx == IDX_CTRL)
                wd_r <= avs_writedata[CTRL_WD_BIT];
            for (int i = 0; i < NUM_MOD; i++) begin
                if (i != WD_MODULE || !wd_r) begin
                    if (idx == IDX_MODE0 + 8'(i))
                        mode_r[i] <= avs_writedata[7:0];
                    if (idx == IDX_MASK)
                        mode_r[i][MODE_IRQ_BIT] <= avs_writedata[i];
                    if (idx == CMPL[i])
                        mode_r[i][MODE_CMP_BIT] <= 1'b0;
                end
            end
        end
    end
    // Watchdog blanks every mode bit of module 2 while leaving the stored value
    always_comb begin
        for (int i = 0; i < NUM_MOD; i++) begin
            ienW[i] = mode_r[i][MODE_IRQ_BIT] && !(i == WD_MODULE && wd_r);
            drvW[i] = mode_r[i][MODE_CMP_BIT] && !(i == WD_MODULE && wd_r)
                && (mode_r[i][MODE_TOGGLE_BIT] || mode_r[i][MODE_PULSE_BIT]);
        end
    end
    a_wait_answers: assert property (avs_waitrequest && (avs_read || avs_write)
        |=> !avs_waitrequest) else $error("no answer to a request");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_read_byte: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_irq_masked: assert property (irq |-> (|ienW) || $past(|ienW))
        else $error("interrupt with every enable off");
    a_irq_sticky: assert property ($fell(irq) |-> $past(done) || $past(done, 2))
        else $error("interrupt dropped without a register write");
    a_wd_pulse: assert property (wdTimeout |-> (wd_r || $past(wd_r)) ##1 !wdTimeout)
        else $error("bad watchdog timeout pulse");
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        a_pin_owner: assert property (!modIoOeN[g] |-> drvW[g] || $past(drvW[g]))
            else $error("pin driven by an idle module");
        a_mode_readback: assert property (avs_read && !avs_waitrequest
            && idx == IDX_MODE0 + 8'(g) |-> avs_readdata[7:0] == mode_r[g])
            else $error("mode read differs from expected");
    end
endmodule

bind cca_counter_array cca_counter_array_asserts i_chk (.clk_sys, .nrst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .modIoIn, .modIoOut, .modIoOeN, .irq, .wdTimeout);

// ---- dv/cca_pin_model.sv ----
// Purpose: Pad model of the three module pins
// Assumes: Requested levels land just after a clock edge
// Notes: A module that drives its pin wins; the pad yields instead of fighting
module cca_pin_model (
    input wire logic clk_sys,
    input wire logic [2:0] padSet,
    input wire logic [2:0] modIoOut,
    input wire logic [2:0] modIoOeN,
    output logic [2:0] modIoIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Starts low so the first sampled pin level matches the edge detectors after reset
    logic [2:0] pad_r;
    initial begin
        pad_r = 3'h0;
    end
    always @(posedge clk_sys) begin
        pad_r <= padSet;
    end
    assign modIoIn = (modIoOut & ~modIoOeN) | (pad_r & modIoOeN);
endmodule

// ---- dv/cca_counter_array_tb.sv ----
// Purpose: Self-checking bench of the counter array block
// Assumes: Read results are checked off a queue of expected bytes
// Notes: Capture tests keep the counter stopped so captured values are known
module cca_counter_array_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cca_pkg::*;
    localparam logic [7:0] CMPL [3] = '{IDX_CMPL0, IDX_CMPL1, IDX_CMPL2};
    localparam logic [15:0] RUN_SEQ [12] = '{{IDX_CNT_LO, 8'h00}, {IDX_CNT_HI, 8'h00},
        {IDX_CMPL0, 8'h10}, {IDX_CMPH0, 8'h00}, {IDX_CMPL1, 8'h80}, {IDX_CMPH1, 8'h00},
        {IDX_CMPL2, 8'h00}, {IDX_CMPH2, 8'h80}, {IDX_MODE0, 8'h4c}, {IDX_MODE1, 8'h42},
        {IDX_MODE2, 8'hc2}, {IDX_STATUS, 8'h40}};
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, wdTimeout;
    logic [2:0] modIoIn, modIoOut, modIoOeN;
    logic [2:0] padLvl = 3'h0;
    logic [31:0] seed = 32'hd9999510;
    logic [31:0] r;
    logic [7:0] expQ [$];
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int hi [3];
    int tr [3];
    cca_counter_array i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .modIoIn,
        .modIoOut, .modIoOeN, .irq, .wdTimeout);
    cca_pin_model i_pads (.clk_sys, .padSet(padLvl), .modIoOut, .modIoOeN, .modIoIn);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Held until waitrequest is seen low; unused address and lane bits get noise
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
        input logic be0 = 1'b1);
        logic [31:0] w;
        w = rnd();
        @(posedge clk_sys);
        avs_address <= {idx, w[1:0]};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {w[31:8], d};
        avs_byteenable <= {w[7:5], be0};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back(e);
        bus(1'b0, idx, 8'h00);
    endtask
    task automatic measure(input int n);
        logic [2:0] p;
        repeat (4) @(posedge clk_sys);
        p = modIoOut;
        hi = '{default: 0};
        tr = '{default: 0};
        repeat (n) begin
            @(posedge clk_sys);
            for (int i = 0; i < NUM_MOD; i++) begin
                hi[i] += int'(modIoOut[i]);
                tr[i] += int'(modIoOut[i] != p[i]);
            end
            p = modIoOut;
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            print_verdict();
        end
        if (avs_read && avs_waitrequest === 1'b0 && expQ.size() > 0)
            chk(avs_readdata, {24'h0, expQ.pop_front()});
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int i = 0; i < NUM_MOD; i++)
            rd(IDX_MODE0 + 8'(i), MODE_RST);
        rd(IDX_CTRL, 8'(CTRL_WD_RST) << CTRL_WD_BIT);
        rd(IDX_CNT_LO, CNT_RST[7:0]);
        r = rnd();
        bus(1'b1, IDX_MODE2, r[7:0]);
        bus(1'b1, IDX_CNT_LO, 8'ha5);
        rd(IDX_MODE2, MODE_RST);
        rd(IDX_CNT_LO, 8'h00);
        bus(1'b1, IDX_CTRL, 8'h00);
        bus(1'b1, IDX_MODE2, r[7:0]);
        bus(1'b1, IDX_CNT_LO, 8'h33);
        bus(1'b1, IDX_CNT_HI, 8'h12);
        bus(1'b1, IDX_CNT_LO, 8'h77, 1'b0);
        rd(IDX_MODE2, r[7:0]);
        rd(IDX_CNT_LO, 8'h33);
        rd(IDX_CNT_HI, 8'h12);
        rd(8'h00, 8'h00);
        $display("done: register access");
        for (int i = 0; i < NUM_MOD; i++) begin
            bus(1'b1, IDX_MODE0 + 8'(i), 8'hff);
            bus(1'b1, CMPL[i], 8'h00);
            rd(IDX_MODE0 + 8'(i), 8'hbf);
        end
        $display("done: compare enable clear");
        padLvl <= 3'b010;
        bus(1'b1, IDX_MODE0, 8'h21);
        bus(1'b1, IDX_MODE1, 8'h10);
        bus(1'b1, IDX_MODE2, 8'h00);
        bus(1'b1, IDX_STATUS, 8'h07);
        rd(IDX_STATUS, 8'h00);
        padLvl <= 3'b001;
        repeat (4) @(posedge clk_sys);
        chk(32'(irq), 32'h1);
        rd(IDX_STATUS, 8'h03);
        rd(IDX_CMPL0, 8'h33);
        rd(IDX_CMPH1, 8'h12);
        bus(1'b1, IDX_MASK, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        rd(IDX_STATUS, 8'h03);
        bus(1'b1, IDX_STATUS, 8'h03);
        padLvl <= 3'b010;
        repeat (4) @(posedge clk_sys);
        rd(IDX_STATUS, 8'h00);
        $display("done: capture");
        foreach (RUN_SEQ[k])
            bus(1'b1, RUN_SEQ[k][15:8], RUN_SEQ[k][7:0]);
        measure(256);
        chk(32'(hi[1]), 32'd128);
        chk(32'(hi[2]), 32'd0);
        chk(32'(tr[0]), 32'd1);
        chk(32'(modIoOeN), 32'h0);
        rd(IDX_STATUS, 8'h41);
        bus(1'b1, IDX_MODE0, 8'h46);
        measure(512);
        chk(32'(tr[0]), 32'd2);
        $display("done: output modes");
        bus(1'b1, IDX_CTRL, 8'h40);
        repeat (4) @(posedge clk_sys);
        chk(32'(modIoOeN[2]), 32'h1);
        rd(IDX_MODE2, 8'hc2);
        for (int i = 0; i < 40000 && wdTimeout !== 1'b1; i++)
            @(posedge clk_sys);
        chk(32'(wdTimeout), 32'h1);
        $display("done: watchdog");
        @(posedge clk_sys);
        print_verdict();
    end
endmodule
